// [rgc_pkg.sv]
// Purpose: shared constants and types for the remote gauge control block
// Assumes: 250 MHz pclk, 32-bit APB register access
// Notes: remote lines arrive raw and active low, idle high
`default_nettype none
package rgc_pkg;
	localparam int CNT_W = 24;
	localparam int ADDR_W = 12;
	localparam int CFG_W = 5;
	localparam int CMD_W = 6;
	localparam int NRI = 10;
	localparam int BLK_W = 9;

	// Times in their own units, counts derived from the clock rate
	localparam int CLK_KHZ = 250000;
	localparam int STABLE_MS = 35;
	localparam int STABLE_CYC_DEF = STABLE_MS * CLK_KHZ;
	localparam int MS_CYC_DEF = CLK_KHZ;
	localparam logic [BLK_W-1:0] BLINK_MS = 9'h0FA;

	localparam logic [ADDR_W-1:0] OFF_CMD = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_CFG = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_DGT = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_STAT = 12'h00C;

	// Command bits, write-only pulses from the computer link
	localparam int CMD_G1_ON = 0;
	localparam int CMD_G1_OFF = 1;
	localparam int CMD_G2_ON = 2;
	localparam int CMD_G2_OFF = 3;
	localparam int CMD_DG_ON = 4;
	localparam int CMD_DG_OFF = 5;

	// Configuration bits
	localparam int CFG_HOST = 0;
	localparam int CFG_CATH_LSB = 1;
	localparam int CFG_RNG_LSB = 3;
	localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
	localparam logic [CNT_W-1:0] DGT_RST = 24'h0927C0;

	// Status bits
	localparam int ST_GAUGE_LSB = 0;
	localparam int ST_DEGAS = 2;
	localparam int ST_FAULT = 3;
	localparam int ST_CATH_LSB = 4;
	localparam int ST_RNG_LSB = 6;
	localparam int ST_LED = 8;
	localparam int ST_SRC_LSB = 9;
	localparam int ST_LVL_LSB = 16;

	typedef enum logic [1:0] {
		SRC_PANEL = 2'b00,
		SRC_REMOTE = 2'b01,
		SRC_HOST = 2'b10
	} rgc_src_t;

	typedef struct packed {
		logic gauge_one_n;
		logic gauge_two_n;
		logic degas_n;
		logic gauge_inhibit_line_n;
		logic kb_disable_n;
		logic remote_enable_n;
		logic backup_cath_one_n;
		logic backup_cath_two_n;
		logic lowrange_one_n;
		logic lowrange_two_n;
	} rgc_rin_t;

	typedef struct packed {
		logic btn_gauge_one;
		logic btn_gauge_two;
		logic btn_degas;
		logic [1:0] sw_cath_backup;
		logic [1:0] sw_range_low;
	} rgc_panel_t;

	typedef struct packed {
		logic [1:0] press_ok;
		logic [1:0] degas_ok;
		logic [1:0] aux_on;
		logic [1:0] aux_off;
		logic fault;
	} rgc_gauge_in_t;

	typedef struct packed {
		logic gauge_one_on;
		logic gauge_two_on;
		logic degas_on;
		logic fault;
	} rgc_relay_t;

	typedef struct packed {
		logic [1:0] cath_backup;
		logic [1:0] range_low;
		logic remote_led;
	} rgc_param_t;

	typedef struct packed {
		logic [1:0] gauge_on;
		logic degas;
		logic [CNT_W-1:0] dg_cnt;
		logic [CFG_W-1:0] cfg;
		logic [CNT_W-1:0] dgt;
		logic [31:0] prdata;
		logic fault;
		logic [1:0] cath;
		logic [1:0] rng;
		logic led;
	} rgc_st_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic lvl;
		logic [CNT_W-1:0] cnt;
		logic rise;
		logic fall;
	} rgc_qst_t;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic ms_tick;
		logic [BLK_W-1:0] bcnt;
		logic blink;
	} rgc_tst_t;

	// Parameter source priority: remote, then computer link, then panel
	function automatic logic sel_param(rgc_src_t src, logic rem, logic host,
			logic pnl);
		logic r;
		r = pnl;
		if (src == SRC_REMOTE) begin
			r = rem;
		end else if (src == SRC_HOST) begin
			r = host;
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// [rgc_qual.sv]
// Purpose: synchronise one remote line and qualify its transitions
// Assumes: line idles high; stable_cyc is at least one
// Notes: rise/fall pulse only after the old level held stable_cyc cycles
`default_nettype none
module rgc_qual
	import rgc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic raw,
	input wire logic [CNT_W-1:0] stable_cyc,
	output logic lvl,
	output logic rise,
	output logic fall
);
	rgc_qst_t st_reg;
	rgc_qst_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = raw;
		st_next.s2 = st_reg.s1;
		st_next.rise = 1'b0;
		st_next.fall = 1'b0;
		if (st_reg.s2 != st_reg.lvl) begin
			// Any change restarts the count; it acts only if the old level was stable
			st_next.lvl = st_reg.s2;
			st_next.cnt = '0;
			st_next.rise = st_reg.s2 && (st_reg.cnt >= stable_cyc);
			st_next.fall = !st_reg.s2 && (st_reg.cnt >= stable_cyc);
		end else if (st_reg.cnt < stable_cyc) begin
			st_next.cnt = st_reg.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, cnt: '0,
				rise: 1'b0, fall: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign lvl = st_reg.lvl;
	assign rise = st_reg.rise;
	assign fall = st_reg.fall;
endmodule
`default_nettype wire

// [rgc_tick.sv]
// Purpose: millisecond enable pulse and indicator flash level
// Assumes: ms_cyc is at least one
// Notes: flash half period is BLINK_MS milliseconds
`default_nettype none
module rgc_tick
	import rgc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [CNT_W-1:0] ms_cyc,
	output logic ms_tick,
	output logic blink
);
	rgc_tst_t st_reg;
	rgc_tst_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.ms_tick = 1'b0;
		if (st_reg.cnt + CNT_W'(1) >= ms_cyc) begin
			st_next.cnt = '0;
			st_next.ms_tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + CNT_W'(1);
		end
		if (st_reg.ms_tick) begin
			if (st_reg.bcnt + BLK_W'(1) >= BLINK_MS) begin
				st_next.bcnt = '0;
				st_next.blink = !st_reg.blink;
			end else begin
				st_next.bcnt = st_reg.bcnt + BLK_W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign ms_tick = st_reg.ms_tick;
	assign blink = st_reg.blink;
endmodule
`default_nettype wire

// [rgc_top.sv]
// Purpose: remote input control of two ion gauges, degas and parameters
// Assumes: APB3 slave, zero wait states, one aligned word per register
// Notes: computer link commands arrive through the command register
//
// Decided for this implementation: the APB slave port and the register addresses.
`default_nettype none
module rgc_top
	import rgc_pkg::*;
#(
	parameter logic [CNT_W-1:0] STABLE_CYC = CNT_W'(STABLE_CYC_DEF),
	parameter logic [CNT_W-1:0] MS_CYC = CNT_W'(MS_CYC_DEF)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rgc_rin_t remote_n,
	input wire rgc_panel_t panel,
	input wire rgc_gauge_in_t gauge_in,
	output rgc_relay_t relay,
	output rgc_param_t param
);
	rgc_st_t st_reg;
	rgc_st_t st_next;
	rgc_rin_t lvl;
	rgc_rin_t rise;
	rgc_rin_t fall;
	logic ms_tick;
	logic blink;
	logic apb_wr;
	logic apb_rd_setup;
	logic hit;
	logic [CMD_W-1:0] host_cmd;
	logic inhibit;
	logic kb_en;
	logic [1:0] rq_on;
	logic [1:0] rq_off;
	logic [1:0] on_ok;
	logic [1:0] g_next;
	logic dg_start_rq;
	logic dg_stop_rq;
	logic dg_allowed;
	logic dg_expire;
	rgc_src_t src;
	logic [31:0] rdata;

	function automatic logic addr_hit(logic [ADDR_W-1:0] a);
		return (a == OFF_CMD) || (a == OFF_CFG) || (a == OFF_DGT) ||
			(a == OFF_STAT);
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < NRI; gi++) begin : g_qual
			rgc_qual u_qual (
				.pclk(pclk),
				.presetn(presetn),
				.raw(remote_n[gi]),
				.stable_cyc(STABLE_CYC),
				.lvl(lvl[gi]),
				.rise(rise[gi]),
				.fall(fall[gi])
			);
		end
	endgenerate

	rgc_tick u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.ms_cyc(MS_CYC),
		.ms_tick(ms_tick),
		.blink(blink)
	);

	// Zero wait states; unmapped offsets answer with an error
	assign pready = 1'b1;
	assign hit = addr_hit(paddr);
	assign pslverr = psel && penable && !hit;
	assign apb_wr = psel && penable && pwrite && hit;
	assign apb_rd_setup = psel && !penable && !pwrite;
	assign host_cmd = (apb_wr && paddr == OFF_CMD) ?
		pwdata[CMD_W-1:0] : '0;

	// Lines read high when open, so a low level is the active one
	assign inhibit = !lvl.gauge_inhibit_line_n;
	assign kb_en = lvl.kb_disable_n;

	// Turn-on and turn-off requests from every source; remote lines by edge, panel and aux by level
	always_comb begin
		rq_on[0] = fall.gauge_one_n || gauge_in.aux_on[0] ||
			host_cmd[CMD_G1_ON] ||
			(kb_en && panel.btn_gauge_one && !st_reg.gauge_on[0]);
		rq_on[1] = fall.gauge_two_n || gauge_in.aux_on[1] ||
			host_cmd[CMD_G2_ON] ||
			(kb_en && panel.btn_gauge_two && !st_reg.gauge_on[1]);
		rq_off[0] = rise.gauge_one_n || gauge_in.aux_off[0] ||
			host_cmd[CMD_G1_OFF] ||
			(kb_en && panel.btn_gauge_one && st_reg.gauge_on[0]);
		rq_off[1] = rise.gauge_two_n || gauge_in.aux_off[1] ||
			host_cmd[CMD_G2_OFF] ||
			(kb_en && panel.btn_gauge_two && st_reg.gauge_on[1]);
		on_ok = rq_on & gauge_in.press_ok & {2{!inhibit}};
	end

	always_comb begin
		g_next = st_reg.gauge_on & ~rq_off;
		// Gauge one wins a simultaneous turn-on of both
		if (on_ok[0]) begin
			g_next = 2'b01;
		end else if (on_ok[1]) begin
			g_next = 2'b10;
		end
		if (inhibit) begin
			g_next = 2'b00;
		end
	end

	// Degas, tied to whichever gauge is on
	assign dg_allowed = |(g_next & gauge_in.degas_ok);
	assign dg_expire = st_reg.degas && ms_tick &&
		(st_reg.dg_cnt <= CNT_W'(1));
	assign dg_start_rq = fall.degas_n || host_cmd[CMD_DG_ON] ||
		(kb_en && panel.btn_degas && !st_reg.degas);
	assign dg_stop_rq = rise.degas_n || host_cmd[CMD_DG_OFF] ||
		(kb_en && panel.btn_degas && st_reg.degas) || dg_expire;

	always_comb begin
		if (!lvl.remote_enable_n) begin
			src = SRC_REMOTE;
		end else if (st_reg.cfg[CFG_HOST]) begin
			src = SRC_HOST;
		end else begin
			src = SRC_PANEL;
		end
	end

	always_comb begin
		rdata = '0;
		unique case (paddr)
			OFF_CFG: rdata[CFG_W-1:0] = st_reg.cfg;
			OFF_DGT: rdata[CNT_W-1:0] = st_reg.dgt;
			OFF_STAT: begin
				rdata[ST_GAUGE_LSB +: 2] = st_reg.gauge_on;
				rdata[ST_DEGAS] = st_reg.degas;
				rdata[ST_FAULT] = st_reg.fault;
				rdata[ST_CATH_LSB +: 2] = st_reg.cath;
				rdata[ST_RNG_LSB +: 2] = st_reg.rng;
				rdata[ST_LED] = st_reg.led;
				rdata[ST_SRC_LSB +: 2] = src;
				rdata[ST_LVL_LSB +: NRI] = lvl;
			end
			default: rdata = '0;
		endcase
	end

	always_comb begin
		st_next = st_reg;
		st_next.gauge_on = g_next;
		if (!(|g_next) || (st_reg.degas && dg_stop_rq)) begin
			st_next.degas = 1'b0;
		end else if (!st_reg.degas && dg_start_rq && dg_allowed) begin
			st_next.degas = 1'b1;
			st_next.dg_cnt = st_reg.dgt;
		end else if (st_reg.degas && ms_tick) begin
			st_next.dg_cnt = st_reg.dg_cnt - CNT_W'(1);
		end
		if (apb_wr && paddr == OFF_CFG) begin
			st_next.cfg = pwdata[CFG_W-1:0];
		end
		if (apb_wr && paddr == OFF_DGT) begin
			st_next.dgt = pwdata[CNT_W-1:0];
		end
		if (apb_rd_setup) begin
			st_next.prdata = rdata;
		end
		st_next.fault = gauge_in.fault;
		st_next.cath[0] = sel_param(src, !lvl.backup_cath_one_n,
			st_reg.cfg[CFG_CATH_LSB], panel.sw_cath_backup[0]);
		st_next.cath[1] = sel_param(src, !lvl.backup_cath_two_n,
			st_reg.cfg[CFG_CATH_LSB + 1], panel.sw_cath_backup[1]);
		st_next.rng[0] = sel_param(src, !lvl.lowrange_one_n,
			st_reg.cfg[CFG_RNG_LSB], panel.sw_range_low[0]);
		st_next.rng[1] = sel_param(src, !lvl.lowrange_two_n,
			st_reg.cfg[CFG_RNG_LSB + 1], panel.sw_range_low[1]);
		st_next.led = (src == SRC_REMOTE) ||
			((src == SRC_HOST) && blink);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '{gauge_on: 2'b00, degas: 1'b0, dg_cnt: '0,
				cfg: CFG_RST, dgt: DGT_RST, prdata: '0, fault: 1'b0,
				cath: 2'b00, rng: 2'b00, led: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign relay.gauge_one_on = st_reg.gauge_on[0];
	assign relay.gauge_two_on = st_reg.gauge_on[1];
	assign relay.degas_on = st_reg.degas;
	assign relay.fault = st_reg.fault;
	assign param.cath_backup = st_reg.cath;
	assign param.range_low = st_reg.rng;
	assign param.remote_led = st_reg.led;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_inhibit_off: assert property (
		inhibit |=> (relay.gauge_one_on == 1'b0 && relay.gauge_two_on == 1'b0))
		else $error("gauge on while inhibit line low");
	chk_one_gauge: assert property (
		!(relay.gauge_one_on && relay.gauge_two_on))
		else $error("both gauges on together");
	chk_remote_on: assert property (
		(fall.gauge_one_n && !inhibit && gauge_in.press_ok[0])
		|=> relay.gauge_one_on && !relay.gauge_two_on)
		else $error("qualified remote fall did not turn gauge one on");
	chk_remote_off: assert property (
		(rise.gauge_two_n && !on_ok[1]) |=> !relay.gauge_two_on)
		else $error("qualified remote rise did not turn gauge two off");
	chk_degas_gauge: assert property (
		relay.degas_on |-> (relay.gauge_one_on || relay.gauge_two_on))
		else $error("degas running without a gauge on");
	chk_degas_start: assert property (
		(fall.degas_n && !st_reg.degas && dg_allowed && !dg_stop_rq)
		|=> relay.degas_on)
		else $error("qualified degas fall did not start degas");
	chk_degas_timeout: assert property (
		(st_reg.degas && ms_tick && st_reg.dg_cnt == CNT_W'(1))
		|=> !relay.degas_on)
		else $error("degas outlived its programmed time");
	chk_kb_block: assert property (
		(!kb_en && panel.btn_gauge_one && !fall.gauge_one_n &&
		!gauge_in.aux_on[0] && !host_cmd[CMD_G1_ON] && !relay.gauge_one_on)
		|=> !relay.gauge_one_on)
		else $error("disabled panel button turned gauge one on");
	chk_remote_param: assert property (
		(!lvl.remote_enable_n && $stable(lvl)) [*2]
		|-> param.cath_backup == {!lvl.backup_cath_two_n,
		!lvl.backup_cath_one_n} && param.range_low ==
		{!lvl.lowrange_two_n, !lvl.lowrange_one_n})
		else $error("remote cathode or range selection not applied");
	chk_led_mode: assert property (
		(src == SRC_PANEL) [*2] |-> !param.remote_led)
		else $error("indicator lit under panel control");

	cov_remote_on: cover property (fall.gauge_one_n ##1 relay.gauge_one_on);
	cov_switch_over: cover property (
		relay.gauge_one_on ##1 relay.gauge_two_on);
	cov_degas_expire: cover property (dg_expire ##1 !relay.degas_on);
	cov_led_flash: cover property (
		(src == SRC_HOST) && param.remote_led ##1 !param.remote_led);
endmodule
`default_nettype wire

// [rgc_remote_model.sv]
// Purpose: remote controller model driving the isolated input lines
// Assumes: a request bit of one means that line is pulled to common
// Notes: released lines read high, as the pull-up makes them
`default_nettype none
module rgc_remote_model
	import rgc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire rgc_rin_t req,
	output rgc_rin_t remote_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines follow the request one edge late; held low while requested
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remote_n <= '1;
		end else begin
			remote_n <= ~req;
		end
	end
endmodule
`default_nettype wire

// [remote_gauge_control_inputs_test.sv]
// Purpose: self-checking bench for the remote gauge control block
// Assumes: shortened stable and millisecond counts
// Notes: waits include two sync flops, the model flop and the output flop
`default_nettype none
module remote_gauge_control_inputs_test;
	import rgc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [CNT_W-1:0] SC = 24'h000008;
	localparam logic [CNT_W-1:0] MC = 24'h000004;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	rgc_rin_t req, remote_n;
	rgc_panel_t panel;
	rgc_gauge_in_t gauge_in;
	rgc_relay_t relay;
	rgc_param_t param;
	int mismatches, samples_checked, n, m;
	logic [3:0] r, c, p;
	logic seen0, seen1;

	rgc_remote_model u_model (.pclk(pclk), .presetn(presetn), .req(req),
		.remote_n(remote_n));
	rgc_top #(.STABLE_CYC(SC), .MS_CYC(MC)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .remote_n(remote_n), .panel(panel),
		.gauge_in(gauge_in), .relay(relay), .param(param));

	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
			input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
		if (k == 50) begin
			mismatches++;
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never reassigns psel in this step
		@(posedge pclk);
	endtask
	task automatic gg(input logic [1:0] exp);
		chk({relay.gauge_one_on, relay.gauge_two_on}, exp);
	endtask
	function automatic logic [3:0] exp_par(input int md, input logic [3:0] rv,
			input logic [3:0] cv, input logic [3:0] pv);
		return (md == 1) ? rv : (md == 2) ? cv : pv;
	endfunction
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Whole run is near 2800 cycles
	initial begin
		#100000;
		mismatches++;
		test_done();
	end
	initial begin
		void'($urandom(19155));
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		req = '0;
		panel = '0;
		gauge_in = '0;
		gauge_in.press_ok = 2'h3;
		gauge_in.degas_ok = 2'h3;
		tick(20);
		presetn <= 1'b1;
		apb(1'b0, OFF_CFG, 32'h0);
		chk(rd, {27'h0, CFG_RST});
		apb(1'b0, OFF_DGT, 32'h0);
		chk(rd, {8'h00, DGT_RST});
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, OFF_STAT, 32'hFFFF_FFFF);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd[10:0], 32'h0);
		$display("test registers done");
		tick(12);
		req.gauge_one_n <= 1'b1;
		tick(8);
		gg(2'b10);
		req.gauge_one_n <= 1'b0;
		tick(4);
		gg(2'b10);
		tick(12);
		req.gauge_one_n <= 1'b1;
		tick(12);
		req.gauge_one_n <= 1'b0;
		tick(8);
		gg(2'b00);
		tick(4);
		req.gauge_one_n <= 1'b1;
		tick(12);
		gg(2'b10);
		req.gauge_two_n <= 1'b1;
		tick(8);
		gg(2'b01);
		apb(1'b1, OFF_CMD, 32'h1 << CMD_G2_OFF);
		tick(12);
		gg(2'b00);
		apb(1'b1, OFF_CMD, 32'h1 << CMD_G1_ON);
		tick(2);
		gg(2'b10);
		req.gauge_inhibit_line_n <= 1'b1;
		tick(6);
		gg(2'b00);
		apb(1'b1, OFF_CMD, 32'h1 << CMD_G1_ON);
		tick(2);
		gg(2'b00);
		req <= '0;
		gauge_in.press_ok <= 2'b10;
		tick(12);
		apb(1'b1, OFF_CMD, 32'h1 << CMD_G1_ON);
		tick(2);
		gg(2'b00);
		gauge_in.press_ok <= 2'b11;
		$display("test gauges done");
		apb(1'b1, OFF_DGT, 32'h5);
		apb(1'b1, OFF_CMD, 32'h1 << CMD_G1_ON);
		req.degas_n <= 1'b1;
		tick(8);
		chk(relay.degas_on, 1'b1);
		for (n = 0; n < 100 && relay.degas_on === 1'b1; n++) tick(1);
		chk(n >= 8 && n <= 24, 1'b1);
		tick(12);
		chk(relay.degas_on, 1'b0);
		req.degas_n <= 1'b0;
		apb(1'b1, OFF_DGT, 32'd1000);
		tick(12);
		req.degas_n <= 1'b1;
		tick(12);
		req.degas_n <= 1'b0;
		tick(8);
		chk(relay.degas_on, 1'b0);
		tick(12);
		req.degas_n <= 1'b1;
		tick(8);
		chk(relay.degas_on, 1'b1);
		apb(1'b1, OFF_CMD, 32'h1 << CMD_G1_OFF);
		tick(2);
		chk(relay.degas_on, 1'b0);
		req.degas_n <= 1'b0;
		$display("test degas done");
		for (n = 0; n < 2; n++) begin
			req.kb_disable_n <= (n == 0);
			tick(4);
			panel.btn_gauge_one <= 1'b1;
			tick(1);
			panel.btn_gauge_one <= 1'b0;
			tick(3);
			chk(relay.gauge_one_on, n == 1);
		end
		gauge_in.fault <= 1'b1;
		tick(2);
		chk(relay.fault, 1'b1);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd[ST_FAULT], 1'b1);
		$display("test panel and fault done");
		for (n = 0; n < 9; n++) begin
			r = 4'($urandom);
			c = 4'($urandom);
			p = 4'($urandom);
			m = n % 3;
			req.remote_enable_n <= (m == 1);
			req.backup_cath_two_n <= r[3];
			req.backup_cath_one_n <= r[2];
			req.lowrange_two_n <= r[1];
			req.lowrange_one_n <= r[0];
			panel.sw_cath_backup <= p[3:2];
			panel.sw_range_low <= p[1:0];
			apb(1'b1, OFF_CFG, {27'h0, c[1:0], c[3:2], m != 0});
			tick(8);
			chk({param.cath_backup, param.range_low}, exp_par(m, r, c, p));
			if (m != 2) begin
				chk(param.remote_led, m == 1);
			end
		end
		req.remote_enable_n <= 1'b0;
		apb(1'b1, OFF_CFG, 32'h1);
		seen0 = 1'b0;
		seen1 = 1'b0;
		for (n = 0; n < 2400; n++) begin
			tick(1);
			seen0 = seen0 | (param.remote_led === 1'b0);
			seen1 = seen1 | (param.remote_led === 1'b1);
		end
		chk({seen0, seen1}, 2'b11);
		$display("test parameters done");
		test_done();
	end
endmodule
`default_nettype wire
